// ---- hdl/sdadc_consts.vh ----
// Purpose: constants of the delta-sigma converter control block
// Assumes: included by its bare name from the design file
// Notes: offsets are byte addresses on the register bus
`ifndef SDADC_CONSTS_VH
`define SDADC_CONSTS_VH

`define OFS_CTRL_A 4'h0
`define OFS_CTRL_B 4'h4
`define OFS_RESULT 4'h8
`define OFS_IRQ_CTL 4'hc

`define CTRL_A_WMASK 32'h003f007f
`define CTRL_B_WMASK 32'h1f3f00ff
`define CTRL_RESET 32'h00000000
`define MASK_ALL 8'hff

`define A_ON 0
`define A_RUN 1
`define A_OSR_LO 2
`define A_FAST 6
`define A_NREF_LO 16
`define A_PREF_LO 18
`define A_RSHORT 20
`define A_SSHORT 21

`define B_NIN_LO 0
`define B_PIN_LO 4
`define B_PGA_LO 16
`define B_HALF 19
`define B_MGAIN_LO 20
`define B_ZOFS_LO 24
`define B_LADDER 28

`define OSR_MAX_CODE 4'ha
`define OSR_LOG_TOP 4'hf
`define RESULT_SHIFT_UP 23
`define DISCARD_COUNT 2'h2
`define CHOP_HALF_NORMAL 7'h40
`define CHOP_HALF_FAST 7'h10

`define CORE_CLK_HZ 100000000
`define CONV_CLK_HZ 330000

`endif

// ---- hdl/sigma_delta_adc_control.v ----
// Purpose: register file, converter clock, chopper and sinc3 decimator
//          of a 24-bit delta-sigma converter
// Assumes: modulator bit arrives asynchronously on a pin
// Notes: one wait state on every bus access
//
// Our own choice: the Avalon-MM register port.
`include "sdadc_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module sigma_delta_adc_control #(
	parameter integer ACC_W = 48,
	parameter integer CLK_HALF =
		(`CORE_CLK_HZ + 2 * `CONV_CLK_HZ - 1) / (2 * `CONV_CLK_HZ)
) (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	input wire mod_bit_i,
	output reg converter_clock_o,
	output reg chop_o,
	output reg signal_input_short_o,
	output reg reference_input_short_o,
	output reg [3:0] pos_reference_onehot_o,
	output reg [3:0] neg_reference_onehot_o,
	output reg ladder_pin_route_en_o,
	output reg zero_offset_negative_o,
	output reg [2:0] zero_offset_eighths_o,
	output reg [2:0] modulator_gain_o,
	output reg [5:0] preamp_gain_o,
	output reg reference_halving_o,
	output reg [9:0] pos_input_onehot_o,
	output reg [9:0] neg_input_onehot_o,
	output reg [23:0] conversion_value_o,
	output reg result_valid_o,
	output reg result_irq_o
);

	reg [31:0] ctrl_a_q;
	reg [31:0] ctrl_a_d;
	reg [31:0] ctrl_b_q;
	reg [31:0] ctrl_b_d;
	reg irq_en_q;
	reg ack_q;
	reg [31:0] rdata_d;
	reg mod_s1_q;
	reg mod_s2_q;
	reg [15:0] div_q;
	reg tick_q;
	reg [6:0] chop_cnt_q;
	reg signed [ACC_W-1:0] int1_q;
	reg signed [ACC_W-1:0] int2_q;
	reg signed [ACC_W-1:0] int3_q;
	reg signed [ACC_W-1:0] dly1_q;
	reg signed [ACC_W-1:0] dly2_q;
	reg signed [ACC_W-1:0] dly3_q;
	reg [15:0] dec_cnt_q;
	reg [1:0] discard_q;
	reg signed [ACC_W-1:0] comb1;
	reg signed [ACC_W-1:0] comb2;
	reg signed [ACC_W-1:0] comb3;
	reg signed [ACC_W+23:0] scaled;
	reg [23:0] sat_val;
	reg [3:0] log_r;
	reg [15:0] dec_last;
	reg [6:0] chop_half;

	wire wr_take = avs_write_i & ack_q;
	wire on_bit = ctrl_a_q[`A_ON];
	wire run_bit = ctrl_a_q[`A_RUN];
	wire [3:0] osr_code = ctrl_a_q[`A_OSR_LO +: 4];
	wire cic_hold = ~on_bit | ~run_bit;
	wire signed [ACC_W-1:0] step =
		mod_s2_q ? {{(ACC_W-1){1'b0}}, 1'b1} : {ACC_W{1'b1}};

	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;

	// mask-qualified byte writes, except the upper half of control word B, written by byte enable alone; mask bytes are never stored
	always @* begin
		ctrl_a_d = ctrl_a_q;
		ctrl_b_d = ctrl_b_q;
		if (wr_take && avs_address_i == `OFS_CTRL_A) begin
			if (avs_byteenable_i[3] && avs_byteenable_i[2] &&
			    avs_writedata_i[31:24] == `MASK_ALL)
				ctrl_a_d[23:16] = avs_writedata_i[23:16];
			if (avs_byteenable_i[1] && avs_byteenable_i[0] &&
			    avs_writedata_i[15:8] == `MASK_ALL)
				ctrl_a_d[7:0] = avs_writedata_i[7:0];
			ctrl_a_d = ctrl_a_d & `CTRL_A_WMASK;
		end
		if (wr_take && avs_address_i == `OFS_CTRL_B) begin
			if (avs_byteenable_i[3])
				ctrl_b_d[31:24] = avs_writedata_i[31:24];
			if (avs_byteenable_i[2])
				ctrl_b_d[23:16] = avs_writedata_i[23:16];
			if (avs_byteenable_i[1] && avs_byteenable_i[0] &&
			    avs_writedata_i[15:8] == `MASK_ALL)
				ctrl_b_d[7:0] = avs_writedata_i[7:0];
			ctrl_b_d = ctrl_b_d & `CTRL_B_WMASK;
		end
	end

	always @* begin
		case (avs_address_i)
		`OFS_CTRL_A: rdata_d = ctrl_a_q;
		`OFS_CTRL_B: rdata_d = ctrl_b_q;
		`OFS_RESULT: rdata_d = {conversion_value_o, 8'h00};
		`OFS_IRQ_CTL: rdata_d = {31'h00000000, irq_en_q};
		default: rdata_d = 32'h00000000;
		endcase
	end

	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ctrl_a_q <= `CTRL_RESET;
			ctrl_b_q <= `CTRL_RESET;
			irq_en_q <= 1'b0;
			ack_q <= 1'b0;
			avs_readdata_o <= 32'h00000000;
		end else begin
			ctrl_a_q <= ctrl_a_d;
			ctrl_b_q <= ctrl_b_d;
			if (wr_take && avs_address_i == `OFS_IRQ_CTL &&
			    avs_byteenable_i[0])
				irq_en_q <= avs_writedata_i[0];
			ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
			if (avs_read_i && !ack_q)
				avs_readdata_o <= rdata_d;
		end
	end

	// converter clock from the core clock, near 330 kHz, never above
	always @(posedge core_clk_i) begin
		if (!rst_n_i || !on_bit) begin
			div_q <= 16'h0000;
			converter_clock_o <= 1'b0;
			tick_q <= 1'b0;
		end else if (div_q == CLK_HALF[15:0] - 16'h0001) begin
			div_q <= 16'h0000;
			converter_clock_o <= ~converter_clock_o;
			tick_q <= ~converter_clock_o;
		end else begin
			div_q <= div_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			mod_s1_q <= 1'b0;
			mod_s2_q <= 1'b0;
		end else begin
			mod_s1_q <= mod_bit_i;
			mod_s2_q <= mod_s1_q;
		end
	end

	always @* begin
		chop_half = ctrl_a_q[`A_FAST] ? `CHOP_HALF_FAST
			: `CHOP_HALF_NORMAL;
	end

	always @(posedge core_clk_i) begin
		if (!rst_n_i || !on_bit) begin
			chop_cnt_q <= 7'h00;
			chop_o <= 1'b0;
		end else if (tick_q) begin
			if (chop_cnt_q >= chop_half - 7'h01) begin
				chop_cnt_q <= 7'h00;
				chop_o <= ~chop_o;
			end else begin
				chop_cnt_q <= chop_cnt_q + 7'h01;
			end
		end
	end

	// decimation length is two to the power log_r
	always @* begin
		if (osr_code > `OSR_MAX_CODE)
			log_r = `OSR_LOG_TOP;
		else
			log_r = `OSR_LOG_TOP - osr_code;
		dec_last = (16'h0001 << log_r) - 16'h0001;
		comb1 = int3_q - dly1_q;
		comb2 = comb1 - dly2_q;
		comb3 = comb2 - dly3_q;
		// gain is 2^(3*log_r); bring full scale to 2^23
		// kept signed so that the right shift is arithmetic for negatives
		scaled = ($signed({{24{comb3[ACC_W-1]}}, comb3}) <<<
			`RESULT_SHIFT_UP) >>> (3 * log_r);
		if (scaled > $signed({{(ACC_W+1){1'b0}}, 23'h7fffff}))
			sat_val = 24'h7fffff;
		else if (scaled < -$signed({{(ACC_W+1){1'b0}}, 23'h7fffff})
			- 1)
			sat_val = 24'h800000;
		else
			sat_val = scaled[23:0];
	end

	always @(posedge core_clk_i) begin
		if (!rst_n_i || cic_hold) begin
			int1_q <= {ACC_W{1'b0}};
			int2_q <= {ACC_W{1'b0}};
			int3_q <= {ACC_W{1'b0}};
			dly1_q <= {ACC_W{1'b0}};
			dly2_q <= {ACC_W{1'b0}};
			dly3_q <= {ACC_W{1'b0}};
			dec_cnt_q <= 16'h0000;
			discard_q <= 2'h0;
		end else if (tick_q) begin
			int1_q <= int1_q + step;
			int2_q <= int2_q + int1_q;
			int3_q <= int3_q + int2_q;
			if (dec_cnt_q >= dec_last) begin
				dec_cnt_q <= 16'h0000;
				dly1_q <= int3_q;
				dly2_q <= comb1;
				dly3_q <= comb2;
				if (discard_q != `DISCARD_COUNT)
					discard_q <= discard_q + 2'h1;
			end else begin
				dec_cnt_q <= dec_cnt_q + 16'h0001;
			end
		end
	end

	// result held while disabled; only settled outputs are loaded
	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			conversion_value_o <= 24'h000000;
			result_valid_o <= 1'b0;
			result_irq_o <= 1'b0;
		end else if (!cic_hold && tick_q && dec_cnt_q >= dec_last &&
		             discard_q == `DISCARD_COUNT) begin
			conversion_value_o <= sat_val;
			result_valid_o <= 1'b1;
			result_irq_o <= irq_en_q;
		end else begin
			result_valid_o <= 1'b0;
			result_irq_o <= 1'b0;
		end
	end

	// analog switch controls, registered from the control fields
	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			signal_input_short_o <= 1'b0;
			reference_input_short_o <= 1'b0;
			pos_reference_onehot_o <= 4'h1;
			neg_reference_onehot_o <= 4'h1;
			ladder_pin_route_en_o <= 1'b0;
			zero_offset_negative_o <= 1'b0;
			zero_offset_eighths_o <= 3'h0;
			modulator_gain_o <= 3'h1;
			preamp_gain_o <= 6'h01;
			reference_halving_o <= 1'b0;
			pos_input_onehot_o <= 10'h001;
			neg_input_onehot_o <= 10'h001;
		end else begin
			signal_input_short_o <= ctrl_a_q[`A_SSHORT];
			reference_input_short_o <= ctrl_a_q[`A_RSHORT];
			// bit0 supply/ground, bit1 first pin, bit2 second, bit3 buffer
			pos_reference_onehot_o <=
				4'h1 << ctrl_a_q[`A_PREF_LO +: 2];
			neg_reference_onehot_o <=
				4'h1 << ctrl_a_q[`A_NREF_LO +: 2];
			ladder_pin_route_en_o <= ctrl_b_q[`B_LADDER];
			zero_offset_negative_o <= ctrl_b_q[`B_ZOFS_LO + 3];
			zero_offset_eighths_o <= ctrl_b_q[`B_ZOFS_LO +: 3];
			reference_halving_o <= ctrl_b_q[`B_HALF];
			case (ctrl_b_q[`B_MGAIN_LO +: 2])
			2'h1: modulator_gain_o <= 3'h2;
			2'h3: modulator_gain_o <= 3'h4;
			default: modulator_gain_o <= 3'h1;
			endcase
			case (ctrl_b_q[`B_PGA_LO +: 3])
			3'h0: preamp_gain_o <= 6'h01;
			3'h1: preamp_gain_o <= 6'h08;
			3'h2: preamp_gain_o <= 6'h08;
			3'h3: preamp_gain_o <= 6'h10;
			3'h4: preamp_gain_o <= 6'h10;
			3'h7: preamp_gain_o <= 6'h20;
			default: preamp_gain_o <= 6'h18;
			endcase
			// reserved codes open every switch
			if (ctrl_b_q[`B_PIN_LO +: 4] > 4'h9)
				pos_input_onehot_o <= 10'h000;
			else
				pos_input_onehot_o <=
					10'h001 << ctrl_b_q[`B_PIN_LO +: 4];
			if (ctrl_b_q[`B_NIN_LO +: 4] > 4'h9)
				neg_input_onehot_o <= 10'h000;
			else
				neg_input_onehot_o <=
					10'h001 << ctrl_b_q[`B_NIN_LO +: 4];
		end
	end

endmodule

`default_nettype wire

// ---- verification/sdadc_chk.sv ----
// Purpose: port checks of the converter control block
// Assumes: bound to sigma_delta_adc_control
// Notes: read data is judged at the edge waitrequest is low
`timescale 1ns/1ns
`default_nettype none
module sdadc_chk (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire [31:0] avs_readdata_o,
	input wire avs_waitrequest_o,
	input wire converter_clock_o,
	input wire [3:0] pos_reference_onehot_o,
	input wire [9:0] pos_input_onehot_o,
	input wire [2:0] modulator_gain_o,
	input wire [5:0] preamp_gain_o,
	input wire [23:0] conversion_value_o,
	input wire result_valid_o,
	input wire result_irq_o
);
default clocking @(posedge core_clk_i); endclocking
default disable iff (!rst_n_i);
wire rd_done = avs_read_i && !avs_waitrequest_o;
a_one_wait: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1
	!avs_waitrequest_o) else $error("read wait state wrong");
a_result_low: assert property (rd_done && avs_address_i == 4'h8 |->
	avs_readdata_o[7:0] == 8'h00) else $error("result low byte set");
a_ctrla_pad: assert property (rd_done && avs_address_i == 4'h0 |->
	(avs_readdata_o & 32'hffc0ff80) == 0) else $error("a pad set");
a_ctrlb_pad: assert property (rd_done && avs_address_i == 4'h4 |->
	(avs_readdata_o & 32'he0c0ff00) == 0) else $error("b pad set");
a_unmapped_zero: assert property (rd_done && avs_address_i[1:0] != 0 |->
	avs_readdata_o == 0) else $error("unmapped read");
a_valid_pulse: assert property (result_valid_o |=> !result_valid_o)
	else $error("valid too long");
a_irq_pair: assert property (result_irq_o |-> result_valid_o)
	else $error("irq without result");
a_value_hold: assert property ($changed(conversion_value_o) |->
	result_valid_o) else $error("result moved");
a_ref_onehot: assert property ($onehot(pos_reference_onehot_o))
	else $error("reference select");
a_input_sel: assert property ($onehot0(pos_input_onehot_o))
	else $error("input select");
a_gain_set: assert property (modulator_gain_o inside {1, 2, 4} &&
	preamp_gain_o inside {1, 8, 16, 24, 32}) else $error("gain");
c_valid: cover property (result_valid_o);
c_irq: cover property (result_irq_o);
c_res_read: cover property (rd_done && avs_address_i == 4'h8);
c_conv_clk: cover property ($rose(converter_clock_o));
endmodule
`default_nettype wire

// ---- verification/sigma_delta_adc_control_tb_top.sv ----
// Purpose: register and conversion tests of the converter control block
// Assumes: converter clock shortened to four core clocks
// Notes: bus answers are taken at the rising edge, other outputs at the falling
`timescale 1ns/1ns
`default_nettype none
module sigma_delta_adc_control_tb_top;
localparam int HALF = 2;
logic core_clk_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0;
logic mod_bit_i = 0;
logic [3:0] avs_address_i = 0, avs_byteenable_i = 4'hf;
logic [31:0] avs_writedata_i = 0, q;
wire [31:0] avs_readdata_o;
wire avs_waitrequest_o, converter_clock_o, chop_o, signal_input_short_o;
wire reference_input_short_o, ladder_pin_route_en_o, zero_offset_negative_o;
wire reference_halving_o, result_valid_o, result_irq_o;
wire [3:0] pos_reference_onehot_o, neg_reference_onehot_o;
wire [2:0] zero_offset_eighths_o, modulator_gain_o;
wire [5:0] preamp_gain_o;
wire [9:0] pos_input_onehot_o, neg_input_onehot_o;
wire [23:0] conversion_value_o;
int bad_count = 0, comparisons = 0, n;
logic [5:0] pg [8] = '{1, 8, 8, 16, 16, 24, 24, 32};
logic [2:0] mg [4] = '{1, 2, 1, 4};
sigma_delta_adc_control #(.CLK_HALF(HALF)) DUT (.core_clk_i, .rst_n_i,
	.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
	.avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .mod_bit_i,
	.converter_clock_o, .chop_o, .signal_input_short_o,
	.reference_input_short_o, .pos_reference_onehot_o,
	.neg_reference_onehot_o, .ladder_pin_route_en_o, .zero_offset_negative_o,
	.zero_offset_eighths_o, .modulator_gain_o, .preamp_gain_o,
	.reference_halving_o, .pos_input_onehot_o, .neg_input_onehot_o,
	.conversion_value_o, .result_valid_o, .result_irq_o);
initial begin
	forever #5 core_clk_i = ~core_clk_i;
end
task chk(input logic [31:0] g, input logic [31:0] e);
	comparisons++;
	if (g !== e) begin
		bad_count++;
		$display("Error at %0t: got %h expected %h", $time, g, e);
	end
endtask
task stop_test;
	$display("mismatches %0d comparisons %0d", bad_count, comparisons);
	if (bad_count == 0 && comparisons > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
// one access: raised after an edge, held until waitrequest is seen low
task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
	input logic [3:0] b);
	int k;
	k = 0;
	@(posedge core_clk_i);
	avs_write_i <= w;
	avs_read_i <= !w;
	avs_address_i <= a;
	avs_writedata_i <= d;
	avs_byteenable_i <= b;
	@(posedge core_clk_i);
	while (avs_waitrequest_o !== 1'b0 && k < 50) begin
		@(posedge core_clk_i);
		k++;
	end
	if (k == 50)
		chk(k, 0);
	q = avs_readdata_o;
	avs_write_i <= 0;
	avs_read_i <= 0;
endtask
task rd(input logic [3:0] a, input logic [31:0] e);
	bus(0, a, 0, 4'hf);
	chk(q, e);
endtask
task settle;
	repeat (2) @(negedge core_clk_i);
endtask
// falling chopper edge to the next rising one, in core clocks
task chop_half_period;
	@(negedge chop_o);
	n = 0;
	@(negedge core_clk_i);
	while (chop_o !== 1'b1 && n < 500) begin
		@(negedge core_clk_i);
		n++;
	end
endtask
// counts falling edges until the next result pulse
task wv;
	n = 0;
	@(negedge core_clk_i);
	while (result_valid_o !== 1'b1 && n < 5000) begin
		@(negedge core_clk_i);
		n++;
	end
endtask
initial begin
	repeat (20000) @(posedge core_clk_i);
	bad_count++;
	stop_test;
end
initial begin
	repeat (8) @(posedge core_clk_i);
	rst_n_i <= 1;
	rd(4'h0, 0);
	rd(4'h4, 0);
	rd(4'h8, 0);
	bus(1, 4'h0, 32'h003f007f, 4'hf);
	rd(4'h0, 0);
	bus(1, 4'h0, 32'hff3f0000, 4'h3);
	rd(4'h0, 0);
	bus(1, 4'h1, 32'hffffffff, 4'hf);
	rd(4'h1, 0);
	bus(1, 4'h4, 32'hff3fffff, 4'hf);
	rd(4'h4, 32'h1f3f00ff);
	for (int i = 0; i < 10; i++) begin
		bus(1, 4'h4, {3'h0, i[0], i[3:0], 2'h0, i[1:0], i[0], i[2:0],
			8'hff, i[3:0], i[3:0]}, 4'hf);
		settle;
		chk(pos_input_onehot_o, 32'h1 << i);
		chk(neg_input_onehot_o, 32'h1 << i);
		chk(preamp_gain_o, pg[i[2:0]]);
		chk(modulator_gain_o, mg[i[1:0]]);
		chk({zero_offset_negative_o, zero_offset_eighths_o}, i[3:0]);
		chk(reference_halving_o, i[0]);
		chk(ladder_pin_route_en_o, i[0]);
	end
	bus(1, 4'h4, 32'h0000ffab, 4'hf);
	settle;
	chk(pos_input_onehot_o, 0);
	chk(neg_input_onehot_o, 0);
	for (int j = 0; j < 4; j++) begin
		bus(1, 4'h0, {8'hff, 2'h0, j[1:0], j[1:0], ~j[1:0], 16'h0}, 4'hf);
		settle;
		chk(pos_reference_onehot_o, 32'h1 << j);
		chk(neg_reference_onehot_o, 32'h1 << (3 - j));
		chk({signal_input_short_o, reference_input_short_o}, j[1:0]);
	end
	bus(1, 4'hc, 32'h1, 4'hf);
	mod_bit_i <= 1;
	bus(1, 4'h0, 32'h0000ff69, 4'hf);
	bus(1, 4'h0, 32'h0000ff6b, 4'hf);
	wv;
	chk(n > 2 * 32 * 2 * HALF && n <= 3 * 32 * 2 * HALF + 8, 1);
	chk(result_irq_o, 1);
	@(posedge converter_clock_o);
	n = 0;
	@(negedge core_clk_i);
	while (converter_clock_o !== 1'b0 && n < 50) begin
		@(negedge core_clk_i);
		n++;
	end
	chk(n, HALF);
	chop_half_period;
	chk(n, 16 * 2 * HALF);
	wv;
	rd(4'h8, 32'h7fffff00);
	mod_bit_i <= 0;
	repeat (4) wv;
	rd(4'h8, 32'h80000000);
	bus(1, 4'h0, 32'h0000ff29, 4'hf);
	chop_half_period;
	chk(n, 64 * 2 * HALF);
	// run cleared, then enable cleared: no result may arrive
	foreach (pg[k]) if (k < 2) begin
		bus(1, 4'h0, k ? 32'h0000ff02 : 32'h0000ff69, 4'hf);
		mod_bit_i <= 1;
		n = 0;
		repeat (600) @(negedge core_clk_i) n += result_valid_o;
		chk(n, 0);
		rd(4'h8, 32'h80000000);
	end
	chk(converter_clock_o, 0);
	stop_test;
end
endmodule
bind sigma_delta_adc_control sdadc_chk u_chk (.core_clk_i, .rst_n_i,
	.avs_address_i, .avs_read_i, .avs_readdata_o, .avs_waitrequest_o,
	.converter_clock_o, .pos_reference_onehot_o, .pos_input_onehot_o,
	.modulator_gain_o, .preamp_gain_o, .conversion_value_o, .result_valid_o,
	.result_irq_o);
`default_nettype wire
